// ===== tb.sv
// tb: self-checking bench for the event selector
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tes_pkg::*;
    logic clk = 0;
    logic reset = 1;
    tes_axi_req_s q = '0;
    tes_axi_rsp_s p;
    logic [63:0] r;
    logic [3:0] inst = 0;
    logic trg, teg, e;
    logic [127:0] res;
    logic [31:0] d;
    logic [1:0] rr;
    logic [6:0] b;
    int n_errors = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    tes_src tes_src_i (.clk(clk), .r(r));
    tes_event_select tes_event_select_i (.clk(clk), .reset(reset),
        .axi_req(q), .axi_rsp(p), .sac_hit(r[15:0]), .arc_hit(r[23:16]),
        .waypoint(r[24]), .cid_ok(r[25]), .sec_ok(r[26]), .mode_ok(r[27]),
        .virtual_machine_id_ok(r[28]), .inst_res(inst), .wpt_in(r[36:29]),
        .wpt_sample(r[37]), .ctr_hit_zero(r[41:38]),
        .ctr_reload(r[45:42]), .seq_state(r[47:46]),
        .cid_match(r[50:48]), .vm_match(r[51]), .start_stop(r[52]),
        .ext_in(r[56:53]), .xext_sel(r[60:57]), .non_secure(r[61]),
        .trace_prohibited(r[62]), .trigger_event(trg),
        .trace_gate_event(teg), .resources(res));
    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // address and data offered together, released once both are taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        q <= '{awvalid: 1, awaddr: a, wvalid: 1, wdata: v, wstrb: 4'hF,
            bready: 1, default: 0};
        do @(posedge clk); while (!(p.awready && p.wready));
        q <= '{bready: 1, default: 0};
        do @(posedge clk); while (!p.bvalid);
        q <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a);
        q <= '{arvalid: 1, araddr: a, rready: 1, default: 0};
        do @(posedge clk); while (!p.arready);
        q <= '{rready: 1, default: 0};
        do @(posedge clk); while (!p.rvalid);
        d = p.rdata;
        rr = p.rresp;
        q <= '0;
        @(posedge clk);
    endtask
    // reference boolean forms, indexed by function code
    function automatic logic ev(input int f, input int a, input int b);
        int t[8];
        t = '{a, !a, a && b, !a && b, !a && !b, a || b, !a || b, !a || !b};
        return t[f];
    endfunction
    task automatic final_report;
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        d = $urandom(32'h7a811e99);
        repeat (10) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        rd(ADDR_TRIGGER);
        chk(d, {15'h0, EVT_RESET});
        chk(trg, 0);
        // every function code; single forms get a random B field
        for (int f = 0; f < 8; f++) begin
            b = f < 2 ? 7'($urandom) : 7'h19;
            wr(ADDR_TRACE_EN, {15'h0, 3'(f), b, 7'h18});
            rd(ADDR_TRACE_EN);
            chk(d, {15'h0, 3'(f), b, 7'h18});
            for (int k = 0; k < 9; k++) begin
                @(posedge clk);
                if (k > 0) chk(teg, e);
                e = ev(f, inst[0], inst[1]);
                inst <= 4'($urandom);
            end
        end
        wr(ADDR_TRIGGER, 32'h0000006F);
        repeat (2) @(posedge clk);
        chk(trg, 1);
        wr(ADDR_WPT_CTRL, 32'h000000A5);
        rd(ADDR_WPT_CTRL);
        chk(d, 32'h000000A5);
        rd(ADDR_CFG_EXT);
        chk(d, 32'h00288800);
        rd(12'h100);
        chk(rr, RESP_SLVERR);
        chk(d, 0);
        final_report;
    end
    // hang guard, far beyond the roughly 150 cycles the run needs
    initial begin
        #200000;
        n_errors++;
        final_report;
    end
endmodule
`default_nettype wire

// ===== tes_chk.sv
// tes_chk: resource timing checks at the event selector ports
`default_nettype none
module tes_chk
    import tes_pkg::*;
(
    input wire logic clk,                // trace unit clock
    input wire logic reset,              // synchronous, active high
    input wire logic [15:0] sac_hit,     // raw single matches
    input wire logic [7:0] arc_hit,      // raw range matches
    input wire logic waypoint,           // waypoint pulse
    input wire logic [3:0] inst_res,     // instrumentation levels
    input wire logic [7:0] wpt_in,       // watchpoint inputs
    input wire logic wpt_sample,         // watchpoint sample point
    input wire logic [3:0] ctr_hit_zero, // counter reached zero
    input wire logic [3:0] ctr_reload,   // counter reloaded
    input wire logic [1:0] seq_state,    // sequencer state
    input wire logic [3:0] ext_in,       // external pins
    input wire logic trace_prohibited,   // prohibited level
    input wire logic vm_match,           // vm comparator compare
    input wire logic [127:0] resources   // resource vector
);
    // ------------------------------------------------------------
    // warm-up count: $past must not reach into reset
    // ------------------------------------------------------------
    logic [1:0] up;
    always_ff @(posedge clk) begin
        up <= reset ? 2'h0 : (up == 2'h3 ? up : up + 2'h1);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // resource levels against their causes
    // ------------------------------------------------------------
    a_sac_pulse: assert property (up == 2'h3 |->
        resources[15:0] == $past(sac_hit)) else $error("sac level bad");
    a_arc_set: assert property (up == 2'h3 && $past(arc_hit[0], 2)
        |-> resources[16]) else $error("range hit lost");
    a_arc_clear: assert property (up == 2'h3 &&
        $past(waypoint && !arc_hit[0], 2) |-> !resources[16])
        else $error("range not cleared");
    a_wpt_take: assert property (up == 2'h3 &&
        $past(wpt_sample && wpt_in[0], 2) |-> resources[32])
        else $error("watchpoint sample lost");
    a_ctr_set: assert property (up == 2'h3 &&
        $past(ctr_hit_zero[0], 2) |-> resources[64])
        else $error("counter zero lost");
    a_ctr_clear: assert property (up == 2'h3 &&
        $past(ctr_reload[0] && !ctr_hit_zero[0], 2) |-> !resources[64])
        else $error("counter zero stuck");
    a_inst_level: assert property (up == 2'h3 |->
        resources[27:24] == $past(inst_res)) else $error("inst level bad");
    a_seq_state: assert property (up == 2'h3 |->
        resources[82:80] == 3'(4'h1 << $past(seq_state)))
        else $error("sequencer state bad");
    a_ext_level: assert property (up == 2'h3 |->
        resources[99:96] == $past(ext_in, 3)) else $error("ext level bad");
    a_fixed_sources: assert property (up == 2'h3 |-> resources[111] &&
        resources[110] == $past(trace_prohibited))
        else $error("fixed source bad");
    a_vm_hold: assert property (up == 2'h3 && $past(waypoint, 2) |->
        resources[91] == $past(vm_match, 2)) else $error("vm result bad");
    a_reserved_low: assert property (resources[63:48] == 16'h0000 &&
        resources[127:112] == 16'h0000) else $error("reserved set");
endmodule
bind tes_event_select tes_chk tes_chk_i (.clk, .reset, .sac_hit, .arc_hit,
    .waypoint, .inst_res, .wpt_in, .wpt_sample, .ctr_hit_zero, .ctr_reload,
    .seq_state, .ext_in, .trace_prohibited, .resources, .vm_match);
`default_nettype wire

// ===== tes_event_select.sv
// tes_event_select: resource collection, event evaluation and registers
// Behaviour
// - every resource is one level, high while active, low while inactive
// - resource number is 7 bits: type in top three, index in low four
// - undefined type and index pairs select no resource, read low
// - type 0 index 0-15 are single address comparators, count limited
// - type 1: range comparators index 0-7, instrumentation index 8-11
// - type 2 index 0-7 are watchpoint comparator inputs 1-8
// - type 5: sequencer states, context ids, vm comparator, start/stop
// - type 6: external, extended external, non-secure, prohibited, TRUE
// - single comparator resource is high only in its match cycle
// - range comparator resource holds after match until next waypoint
// - watchpoint resource follows its pulse-or-latch control bit
// - external input resource is high while its input is high
// - function code selects one of eight boolean forms of A and B
// - event register is 17 bits: function 16:14, resource A 6:0
// - single resource functions ignore the resource B field
// - event registers read back when config bit 11 is set
// - reserved or missing resources give undefined readback and event
// - address matches qualified by context, security, mode, vm id
// - watchpoint bit 0 pulses one cycle, bit 1 holds until next sample
// - vm comparator sampled at each waypoint, held until next one
// - counter at zero resource stays active until the counter reloads
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module tes_event_select #(
    parameter int NUM_SAC = 16,       // single comparators, 0-16
    parameter int NUM_INST = 4,       // instrumentation resources, 0-4
    parameter int NUM_WPT = 8,        // watchpoint inputs, 0-8
    parameter int NUM_CTR = 4,        // counters, 0-4
    parameter int NUM_CID = 3,        // context id comparators, 0-3
    parameter int NUM_EXT = 4,        // external inputs, 0-4
    parameter int NUM_XEXT = 4,       // extended input selectors, 0-4
    parameter bit HAS_SEQ = 1'b1,     // sequencer present
    parameter bit HAS_VIRTUAL_MACHINE_ID = 1'b1,    // vm comparator present
    parameter bit HAS_SS = 1'b1,      // start/stop block present
    parameter bit HAS_SECURITY = 1'b1, // security extensions present
    parameter bit EVT_READABLE = 1'b1 // event registers read back
) (
    input wire logic clk,                     // trace unit clock
    input wire logic reset,                   // synchronous, active high
    input wire tes_pkg::tes_axi_req_s axi_req, // register bus request
    output tes_pkg::tes_axi_rsp_s axi_rsp,    // register bus response
    input wire logic [15:0] sac_hit,          // raw single addr matches
    input wire logic [7:0] arc_hit,           // raw range matches
    input wire logic waypoint,                // waypoint processed pulse
    input wire logic cid_ok,                  // context id qualifier
    input wire logic sec_ok,                  // security state qualifier
    input wire logic mode_ok,                 // processor mode qualifier
    input wire logic virtual_machine_id_ok,                 // vm id qualifier
    input wire logic [3:0] inst_res,          // instrumentation levels
    input wire logic [7:0] wpt_in,            // watchpoint comparator ins
    input wire logic wpt_sample,              // watchpoint sample point
    input wire logic [3:0] ctr_hit_zero,      // counter reached zero
    input wire logic [3:0] ctr_reload,        // counter reloaded
    input wire logic [1:0] seq_state,         // sequencer state 0-2
    input wire logic [2:0] cid_match,         // context id comparators
    input wire logic vm_match,                // vm comparator compare
    input wire logic start_stop,              // start/stop resource
    input wire logic [3:0] ext_in,            // external input pins
    input wire logic [3:0] xext_sel,          // extended input selectors
    input wire logic non_secure,              // processor non-secure
    input wire logic trace_prohibited,        // trace prohibited level
    output logic trigger_event,               // trigger event level
    output logic trace_gate_event,            // trace enable event level
    output logic [127:0] resources            // all resource levels
);
    import tes_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // low n bits set; counts above 16 saturate
    function automatic logic [15:0] impl_mask(input int n);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // boolean combination of the two selected resources
    function automatic logic eval_fn(input logic [2:0] code,
                                     input logic a, input logic b);
        logic r;
        r = 1'b0;
        unique case (tes_func_e'(code))
            FN_A: r = a;
            FN_NOT_A: r = ~a;
            FN_A_AND_B: r = a & b;
            FN_NA_AND_B: r = ~a & b;
            FN_NA_AND_NB: r = ~a & ~b;
            FN_A_OR_B: r = a | b;
            FN_NA_OR_B: r = ~a | b;
            FN_NA_OR_NB: r = ~a | ~b;
        endcase
        return r;
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [EVT_W-1:0] trigger_event_select;
    logic [EVT_W-1:0] trace_enable_event_select;
    logic [7:0] watchpoint_behaviour_control;
    logic [3:0] comparator_access_type;
    logic [31:0] config_code_extension;

    // read-only capability word, fixed by the build parameters
    assign config_code_extension =
        (32'(NUM_INST & 7) << CFG_INST_LSB)
        | (32'(EVT_READABLE) << CFG_EVT_READ_BIT)
        | (32'(NUM_WPT & 15) << CFG_WPT_LSB)
        | (32'h1 << CFG_WPT_CTRL_BIT);

    // ----------------------------------------------------------------
    // external pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] ext_meta;
    logic [3:0] ext_sync;

    // two stages, only the second stage feeds logic
    always_ff @(posedge clk) begin
        ext_meta <= ext_in;
        ext_sync <= ext_meta;
    end

    // ----------------------------------------------------------------
    // address comparator qualification
    // ----------------------------------------------------------------
    // each enabled qualifier must agree; disabled ones pass
    wire qual_ok = (~comparator_access_type[ACC_CID_BIT] | cid_ok)
        & (~comparator_access_type[ACC_SEC_BIT] | sec_ok)
        & (~comparator_access_type[ACC_MODE_BIT] | mode_ok)
        & (~comparator_access_type[ACC_VIRTUAL_MACHINE_ID_BIT] | virtual_machine_id_ok);
    wire [15:0] sac_q = sac_hit & {16{qual_ok}};
    wire [7:0] arc_q = arc_hit & {8{qual_ok}};

    // ----------------------------------------------------------------
    // held resources
    // ----------------------------------------------------------------
    logic [7:0] arc_held;
    logic [7:0] wpt_res;
    logic [3:0] ctr_zero;
    logic vm_held;
    wire [7:0] next_wpt_res = wpt_sample ? wpt_in
        : (wpt_res & watchpoint_behaviour_control);

    // a new match in the waypoint cycle wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            arc_held <= 8'h00;
            wpt_res <= 8'h00;
            ctr_zero <= 4'h0;
            vm_held <= 1'b0;
        end else begin
            arc_held <= (arc_held & ~{8{waypoint}}) | arc_q;
            wpt_res <= next_wpt_res;
            ctr_zero <= (ctr_zero & ~ctr_reload) | ctr_hit_zero;
            if (waypoint) begin
                vm_held <= vm_match;
            end
        end
    end

    // ----------------------------------------------------------------
    // resource vector, sixteen bits per type
    // ----------------------------------------------------------------
    // missing resources read low so a stray select never fires
    wire [15:0] m_sac = impl_mask(NUM_SAC);
    wire [15:0] m_arc = impl_mask(NUM_SAC / 2);
    wire [15:0] m_inst = impl_mask(NUM_INST);
    wire [15:0] m_wpt = impl_mask(NUM_WPT);
    wire [15:0] m_ctr = impl_mask(NUM_CTR);
    wire [15:0] m_cid = impl_mask(NUM_CID);
    wire [15:0] m_ext = impl_mask(NUM_EXT);
    wire [15:0] m_xext = impl_mask(NUM_XEXT);
    wire [2:0] seq_hot = {seq_state == 2'h2, seq_state == 2'h1,
                          seq_state == 2'h0} & {3{HAS_SEQ}};
    wire [15:0] grp_sac = sac_q & m_sac;
    wire [15:0] grp_arc_inst = {4'h0, inst_res & m_inst[3:0],
                                arc_held & m_arc[7:0]};
    wire [15:0] grp_wpt = {8'h00, wpt_res & m_wpt[7:0]};
    wire [15:0] grp_ctr = {12'h000, ctr_zero & m_ctr[3:0]};
    wire [15:0] grp_seq_ctx = {start_stop & HAS_SS, 3'h0,
                               vm_held & HAS_VIRTUAL_MACHINE_ID,
                               cid_match & m_cid[2:0], 5'h00,
                               seq_hot};
    wire [15:0] grp_ext = {1'b1, trace_prohibited,
                           non_secure & HAS_SECURITY, 1'b0,
                           xext_sel & m_xext[3:0], 4'h0,
                           ext_sync & m_ext[3:0]};
    // unlisted types and indices stay zero
    wire [127:0] res_vec = {16'h0000, grp_ext, grp_seq_ctx,
                            grp_ctr, 16'h0000, grp_wpt,
                            grp_arc_inst, grp_sac};

    // ----------------------------------------------------------------
    // event evaluation
    // ----------------------------------------------------------------
    // field split of the two stored definitions
    wire [2:0] trg_fn = trigger_event_select[FUNC_LSB +: 3];
    wire [6:0] trg_a = trigger_event_select[RES_A_LSB +: RES_W];
    wire [6:0] trg_b = trigger_event_select[RES_B_LSB +: RES_W];
    wire [2:0] te_fn = trace_enable_event_select[FUNC_LSB +: 3];
    wire [6:0] te_a = trace_enable_event_select[RES_A_LSB +: RES_W];
    wire [6:0] te_b = trace_enable_event_select[RES_B_LSB +: RES_W];
    // the resource number indexes type-major into the vector
    wire trg_ra = res_vec[trg_a];
    wire trg_rb = res_vec[trg_b];
    wire te_ra = res_vec[te_a];
    wire te_rb = res_vec[te_b];
    wire next_trigger = eval_fn(trg_fn, trg_ra, trg_rb);
    wire next_trace_gate = eval_fn(te_fn, te_ra, te_rb);

    // one register stage keeps the consumer paths short
    always_ff @(posedge clk) begin
        if (reset) begin
            trigger_event <= 1'b0;
            trace_gate_event <= 1'b0;
            resources <= 128'h0;
        end else begin
            trigger_event <= next_trigger;
            trace_gate_event <= next_trace_gate;
            resources <= res_vec;
        end
    end

    // ----------------------------------------------------------------
    // register read mux
    // ----------------------------------------------------------------
    wire [31:0] status_word = {8'h00, vm_held, trace_gate_event,
                               trigger_event, 1'b0, ctr_zero,
                               wpt_res, arc_held};
    // readback of events depends on the capability bit
    wire [31:0] trg_rd = EVT_READABLE
        ? {15'h0000, trigger_event_select} : 32'h0000_0000;
    wire [31:0] te_rd = EVT_READABLE
        ? {15'h0000, trace_enable_event_select} : 32'h0000_0000;
    wire [ADDR_W-1:0] ra = {axi_req.araddr[ADDR_W-1:2], 2'b00};
    wire rd_hit = (ra == ADDR_TRIGGER) | (ra == ADDR_TRACE_EN)
        | (ra == ADDR_CFG_EXT) | (ra == ADDR_WPT_CTRL)
        | (ra == ADDR_ACC_TYPE) | (ra == ADDR_STATUS);
    wire [31:0] rd_word = (ra == ADDR_TRIGGER) ? trg_rd
        : (ra == ADDR_TRACE_EN) ? te_rd
        : (ra == ADDR_CFG_EXT) ? config_code_extension
        : (ra == ADDR_WPT_CTRL) ? {24'h000000,
                                   watchpoint_behaviour_control}
        : (ra == ADDR_ACC_TYPE) ? {28'h0000000, comparator_access_type}
        : (ra == ADDR_STATUS) ? status_word : 32'h0000_0000;

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid;
    logic [1:0] bresp;
    wire awready = ~aw_held & ~bvalid;
    wire wready = ~w_held & ~bvalid;
    wire aw_take = axi_req.awvalid & awready;
    wire w_take = axi_req.wvalid & wready;
    // address and data may arrive in either order
    wire wr_go = (aw_held | aw_take) & (w_held | w_take);
    wire [ADDR_W-1:0] wa_raw = aw_held ? aw_addr_q : axi_req.awaddr;
    wire [ADDR_W-1:0] wa = {wa_raw[ADDR_W-1:2], 2'b00};
    wire [31:0] wd = w_held ? w_data_q : axi_req.wdata;
    wire [3:0] ws = w_held ? w_strb_q : axi_req.wstrb;
    wire wr_hit = (wa == ADDR_TRIGGER) | (wa == ADDR_TRACE_EN)
        | (wa == ADDR_WPT_CTRL) | (wa == ADDR_ACC_TYPE);
    wire [31:0] trg_new = merge({15'h0000, trigger_event_select}, wd, ws);
    wire [31:0] te_new = merge({15'h0000, trace_enable_event_select},
                               wd, ws);

    // hold the halves until both are in, then answer once
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr_q <= axi_req.awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data_q <= axi_req.wdata;
                w_strb_q <= axi_req.wstrb;
            end
            if (bvalid & axi_req.bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // register updates; all 17 bits stored, so any selection reads back
    always_ff @(posedge clk) begin
        if (reset) begin
            trigger_event_select <= EVT_RESET;
            trace_enable_event_select <= EVT_RESET;
            watchpoint_behaviour_control <= WPT_CTRL_RESET;
            comparator_access_type <= ACC_RESET;
        end else if (wr_go) begin
            if (wa == ADDR_TRIGGER) begin
                trigger_event_select <= trg_new[EVT_W-1:0];
            end
            if (wa == ADDR_TRACE_EN) begin
                trace_enable_event_select <= te_new[EVT_W-1:0];
            end
            if (wa == ADDR_WPT_CTRL && ws[0]) begin
                watchpoint_behaviour_control <= wd[7:0];
            end
            if (wa == ADDR_ACC_TYPE && ws[0]) begin
                comparator_access_type <= wd[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    wire arready = ~rvalid;

    // one read in flight; data captured at acceptance
    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (axi_req.arvalid & arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid & axi_req.rready) begin
            rvalid <= 1'b0;
        end
    end

    // response bundle
    assign axi_rsp.awready = awready;
    assign axi_rsp.wready = wready;
    assign axi_rsp.bvalid = bvalid;
    assign axi_rsp.bresp = bresp;
    assign axi_rsp.arready = arready;
    assign axi_rsp.rvalid = rvalid;
    assign axi_rsp.rdata = rdata;
    assign axi_rsp.rresp = rresp;

endmodule
`default_nettype wire

// ===== tes_pkg.sv
// tes_pkg: constants, types and register map of the event selector
`default_nettype none
package tes_pkg;

    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_TRIGGER = 10'h002;
    localparam logic [9:0] IDX_TRACE_EN = 10'h008;
    localparam logic [9:0] IDX_CFG_EXT = 10'h0F0;
    localparam logic [9:0] IDX_WPT_CTRL = 10'h0F1;
    localparam logic [9:0] IDX_ACC_TYPE = 10'h0F2;
    localparam logic [9:0] IDX_STATUS = 10'h0F3;
    localparam logic [ADDR_W-1:0] ADDR_TRIGGER = {IDX_TRIGGER, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TRACE_EN = {IDX_TRACE_EN, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CFG_EXT = {IDX_CFG_EXT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_WPT_CTRL = {IDX_WPT_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ACC_TYPE = {IDX_ACC_TYPE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // event definition layout
    // ----------------------------------------------------------------
    localparam int EVT_W = 17;
    localparam int FUNC_LSB = 14;
    localparam int RES_B_LSB = 7;
    localparam int RES_A_LSB = 0;
    localparam int RES_W = 7;
    localparam int TYPE_W = 3;
    localparam int INDEX_W = 4;
    // event forced off: NOT(A) with A = constant TRUE
    localparam logic [EVT_W-1:0] EVT_RESET = 17'h0406F;

    // resource type codes
    localparam logic [2:0] TYPE_SAC = 3'h0;
    localparam logic [2:0] TYPE_ARC_INST = 3'h1;
    localparam logic [2:0] TYPE_WPT = 3'h2;
    localparam logic [2:0] TYPE_CTR = 3'h4;
    localparam logic [2:0] TYPE_SEQ_CTX = 3'h5;
    localparam logic [2:0] TYPE_EXT_MISC = 3'h6;

    // config_code_extension field positions
    localparam int CFG_INST_LSB = 13;
    localparam int CFG_EVT_READ_BIT = 11;
    localparam int CFG_WPT_LSB = 16;
    localparam int CFG_WPT_CTRL_BIT = 21;

    // comparator_access_type qualifier enables
    localparam int ACC_CID_BIT = 0;
    localparam int ACC_SEC_BIT = 1;
    localparam int ACC_MODE_BIT = 2;
    localparam int ACC_VIRTUAL_MACHINE_ID_BIT = 3;
    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic [7:0] WPT_CTRL_RESET = 8'h00;

    // boolean function codes
    typedef enum logic [2:0] {
        FN_A = 3'b000,
        FN_NOT_A = 3'b001,
        FN_A_AND_B = 3'b010,
        FN_NA_AND_B = 3'b011,
        FN_NA_AND_NB = 3'b100,
        FN_A_OR_B = 3'b101,
        FN_NA_OR_B = 3'b110,
        FN_NA_OR_NB = 3'b111
    } tes_func_e;

    // AXI4-Lite request and response bundles
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } tes_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tes_axi_rsp_s;

endpackage
`default_nettype wire

// ===== tes_src.sv
// tes_src: random stand-in for the core and comparators feeding resources
`default_nettype none
module tes_src (
    input wire logic clk,          // trace unit clock
    output logic [63:0] r = '0     // packed resource inputs
);
    timeunit 1ns;
    timeprecision 1ns;
    // fresh levels every edge; the real core is no kinder than this
    always @(posedge clk) begin
        r <= {$urandom, $urandom};
    end
endmodule
`default_nettype wire
